/* smp_master.sv */
// serial master port: full duplex, double buffered, four clock modes
//
// Contract
// - master only: drives clock and out-data, samples in-data
// - no select output; selects come elsewhere
// - each bit period shifts out and captures in
// - transmit and receive words double buffered
// - four clock modes, fixed before a transfer
// - pins stay inputs until port is opened
`timescale 1ns/10ps
`default_nettype none
module smp_master (
  input wire logic i_clk, // system clock, 100 MHz
  input wire logic i_rst, // async reset, active high
  input wire logic i_open, // port opened by software
  input wire logic [1:0] i_mode, // clock mode 0..3
  input wire logic [7:0] i_div, // half period in clocks, 0 acts as 1
  input wire logic [7:0] i_tx_data, // word to queue
  input wire logic i_tx_valid, // queue request
  output logic o_tx_ready, // transmit holding buffer empty
  output logic [7:0] o_rx_data, // last received word
  output logic o_rx_valid, // one-cycle pulse, new word
  output logic o_busy, // shift in progress
  input wire logic i_miso, // serial in-data pin
  output logic o_sck, // serial clock pin value
  output logic o_sck_oe_n, // clock pin enable, low drives
  output logic o_mosi, // serial out-data pin value
  output logic o_mosi_oe_n // out-data pin enable, low drives
);
  import smp_pkg::*;

  // state
  smp_state_e state, next_state;
  logic [7:0] hold, next_hold;
  logic hold_full, next_hold_full;
  logic [7:0] shreg, next_shreg;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] divcnt, next_divcnt;
  logic [1:0] cur_mode, next_cur_mode;
  logic [7:0] rx, next_rx;
  logic rxv, next_rxv;
  logic sck, next_sck;
  logic mosi, next_mosi;
  logic oe_n, next_oe_n;
  logic miso_s1, miso_s2;
  logic sampled, next_sampled;
  // registered status outputs
  logic busy, next_busy;
  logic ready, next_ready;

  // two-flop synchroniser for the in-data pin
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      miso_s1 <= i_miso;
      miso_s2 <= miso_s1;
    end
  end

  // next values: buffers, divider, shifter
  always_comb begin
    logic tick;
    logic cpha;
    tick = 1'b0;
    cpha = cur_mode[SMP_MODE_CPHA_BIT];
    next_state = state;
    next_hold = hold;
    next_hold_full = hold_full;
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_divcnt = divcnt;
    next_cur_mode = cur_mode;
    next_rx = rx;
    next_rxv = 1'b0;
    next_sck = sck;
    next_mosi = mosi;
    next_sampled = sampled;
    next_oe_n = ~i_open;
    // holding buffer accepts while shifting
    if (i_tx_valid && !hold_full && i_open) begin
      next_hold = i_tx_data;
      next_hold_full = 1'b1;
    end
    if (state != SMP_IDLE) begin
      if (divcnt <= 8'h01) begin
        tick = 1'b1;
        next_divcnt = i_div;
      end else begin
        next_divcnt = divcnt - 8'h01;
      end
    end
    case (state)
      SMP_IDLE: begin
        next_sck = i_mode[SMP_MODE_CPOL_BIT];
        next_cur_mode = i_mode;
        if (!i_open) begin
          next_hold_full = 1'b0;
        end else if (hold_full) begin
          next_shreg = hold;
          next_hold_full = 1'b0;
          next_bitcnt = SMP_BITS;
          next_divcnt = i_div;
          next_state = SMP_LEAD;
          next_mosi = hold[7];
        end
      end
      SMP_LEAD: begin
        if (tick) begin
          next_sck = ~sck;
          if (!cpha) begin // first edge samples
            next_sampled = miso_s2;
          end else begin
            next_mosi = shreg[7];
          end
          next_state = SMP_TRAIL;
        end
      end
      SMP_TRAIL: begin
        if (tick) begin
          next_sck = ~sck;
          next_shreg = {shreg[6:0], cpha ? miso_s2 : sampled};
          next_bitcnt = bitcnt - 4'h1;
          if (!cpha) begin
            next_mosi = shreg[6];
          end
          if (bitcnt == 4'h1) begin
            next_rx = {shreg[6:0], cpha ? miso_s2 : sampled};
            next_rxv = 1'b1;
            next_state = SMP_IDLE;
          end else begin
            next_state = SMP_LEAD;
          end
        end
      end
      default: next_state = SMP_IDLE;
    endcase
    // status flags follow the next state, so outputs come from flops
    next_busy = (next_state != SMP_IDLE);
    next_ready = ~next_hold_full;
  end

  // register the state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= SMP_IDLE;
      hold <= SMP_WORD_RST;
      hold_full <= SMP_LINE_RST;
      shreg <= SMP_WORD_RST;
      bitcnt <= SMP_CNT_RST;
      divcnt <= SMP_DIV_RST;
      cur_mode <= SMP_MODE_RST;
      rx <= SMP_WORD_RST;
      rxv <= SMP_LINE_RST;
      sck <= SMP_LINE_RST;
      mosi <= SMP_LINE_RST;
      oe_n <= SMP_OE_N_RST;
      sampled <= SMP_LINE_RST;
      busy <= SMP_LINE_RST;
      ready <= SMP_READY_RST;
    end else begin
      state <= next_state;
      hold <= next_hold;
      hold_full <= next_hold_full;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      divcnt <= next_divcnt;
      cur_mode <= next_cur_mode;
      rx <= next_rx;
      rxv <= next_rxv;
      sck <= next_sck;
      mosi <= next_mosi;
      oe_n <= next_oe_n;
      sampled <= next_sampled;
      busy <= next_busy;
      ready <= next_ready;
    end
  end

  // outputs straight from flops; no select pin exists
  assign o_tx_ready = ready;
  assign o_rx_data = rx;
  assign o_rx_valid = rxv;
  assign o_busy = busy;
  assign o_sck = sck;
  assign o_mosi = mosi;
  assign o_sck_oe_n = oe_n;
  assign o_mosi_oe_n = oe_n;

  // checks
  AST_CLOSED_HIZ: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(!i_open) |-> o_sck_oe_n && o_mosi_oe_n) else $error("pins driven while closed");
  AST_IDLE_POL: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == SMP_IDLE) && $past(state == SMP_IDLE) |-> o_sck == $past(i_mode[1]))
    else $error("idle clock polarity wrong");
  AST_START: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == SMP_IDLE) && hold_full && i_open |=> o_busy && !hold_full)
    else $error("queued word not started");
  AST_RXDONE: assert property (@(posedge i_clk) disable iff (i_rst)
    o_rx_valid |-> !o_busy && $past(o_busy)) else $error("rx pulse outside word end");
  AST_MODE_HELD: assert property (@(posedge i_clk) disable iff (i_rst)
    o_busy && $past(o_busy) |-> $stable(cur_mode)) else $error("mode changed mid word");
  AST_EDGE_PAIR: assert property (@(posedge i_clk) disable iff (i_rst)
    o_busy && $changed(o_sck) && ($past(i_div) > 8'h01) |=> $stable(o_sck))
    else $error("clock edges too close");
  AST_QUEUE: assert property (@(posedge i_clk) disable iff (i_rst)
    i_tx_valid && o_tx_ready && i_open |=> !o_tx_ready || o_busy)
    else $error("queue write lost");
  AST_RX_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_rx_valid |-> $stable(o_rx_data)) else $error("rx word changed");
  COV_MODE0: cover property (@(posedge i_clk) o_rx_valid && cur_mode == 2'h0);
  COV_MODE3: cover property (@(posedge i_clk) o_rx_valid && cur_mode == 2'h3);
  AST_TX_FIRST_BIT: assert property (@(posedge i_clk) disable iff (i_rst)
    o_busy && !$past(o_busy) |-> o_mosi == $past(hold[7])) else $error("first bit not out");
  COV_B2B: cover property (@(posedge i_clk) o_busy && !o_tx_ready);
  COV_MODE1: cover property (@(posedge i_clk) o_rx_valid && cur_mode == 2'h1);
  COV_MODE2: cover property (@(posedge i_clk) o_rx_valid && cur_mode == 2'h2);
endmodule
`default_nettype wire

/* smp_pkg.sv */
// package: constants and types for the serial master port
package smp_pkg;
  localparam int SMP_DATA_W = 8;
  localparam int SMP_DIV_W = 8;
  localparam logic [7:0] SMP_DIV_RST = 8'h04;
  localparam logic [1:0] SMP_MODE_RST = 2'h0;
  localparam logic [7:0] SMP_WORD_RST = 8'h00;
  localparam logic [3:0] SMP_CNT_RST = 4'h0;
  localparam logic SMP_LINE_RST = 1'b0;
  localparam logic SMP_OE_N_RST = 1'b1;
  localparam logic SMP_READY_RST = 1'b1;
  localparam int SMP_MODE_CPOL_BIT = 1;
  localparam int SMP_MODE_CPHA_BIT = 0;
  localparam logic [3:0] SMP_BITS = 4'h8;
  typedef enum logic [1:0] {SMP_IDLE, SMP_LEAD, SMP_TRAIL} smp_state_e;
endpackage

/* smp_slave_model.sv */
// behavioural slave: answers a 16-bit word, records bits heard
`timescale 1ns/10ps
`default_nettype none
module smp_slave_model (
  input wire logic i_sck, // serial clock from master
  input wire logic i_mosi, // out-data from master
  input wire logic i_sel_n, // select, low active
  input wire logic [1:0] i_mode, // clock mode
  input wire logic [15:0] i_word, // answer word
  output logic o_miso = 1'b0, // in-data to master
  output logic [15:0] o_got = 16'h0000 // bits heard
);
  logic [15:0] sh;
  logic first;
  // load on select, garble line when released
  always @(i_sel_n) begin
    sh = i_word;
    first = 1'b1;
    o_miso = (i_sel_n || i_mode[0]) ? ~o_miso : i_word[15];
  end
  // sample on one edge, shift on the other
  always @(i_sck) begin
    if (!i_sel_n) begin
      if (i_sck == (i_mode[1] ^ ~i_mode[0])) begin
        o_got = {o_got[14:0], i_mosi};
      end else begin
        if (!(first && i_mode[0])) sh = sh << 1;
        first = 1'b0;
        o_miso = sh[15];
      end
    end
  end
endmodule
`default_nettype wire

/* tb_spi_master_port.sv */
// self-checking bench for the serial master port
`timescale 1ns/10ps
`default_nettype none
module tb_spi_master_port;
  import smp_pkg::*;
  logic i_clk = 0, i_rst = 1, i_open = 0, i_tx_valid = 0, sel_n = 1;
  logic [1:0] i_mode = 2'h0;
  logic [7:0] i_div = 8'h04, i_tx_data = 8'h00, o_rx_data;
  logic [15:0] word = 16'h0000, got;
  logic o_tx_ready, o_rx_valid, o_busy, i_miso, o_sck, o_sck_oe_n, o_mosi, o_mosi_oe_n;
  int fails = 0, compares = 0, cyc = 0;
  smp_master dut_u (.i_clk, .i_rst, .i_open, .i_mode, .i_div, .i_tx_data, .i_tx_valid,
    .o_tx_ready, .o_rx_data, .o_rx_valid, .o_busy, .i_miso, .o_sck, .o_sck_oe_n,
    .o_mosi, .o_mosi_oe_n);
  smp_slave_model slave_u (.i_sck(o_sck), .i_mosi(o_mosi), .i_sel_n(sel_n),
    .i_mode(i_mode), .i_word(word), .o_miso(i_miso), .o_got(got));
  // clock and cycle ceiling
  initial forever #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      print_verdict;
    end
  end
  task automatic print_verdict;
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick;
    @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] w);
    int n;
    for (n = 0; n < 100 && o_tx_ready !== 1'b1; n++) tick;
    i_tx_data = w;
    i_tx_valid = 1'b1;
    tick;
    i_tx_valid = 1'b0;
  endtask
  task automatic wait_rx;
    int n;
    for (n = 0; n < 200 && o_rx_valid !== 1'b1; n++) tick;
    chk(16'(n < 200), 16'h0001);
  endtask
  // pins stay inputs until opened
  task automatic t_open;
    repeat (3) tick;
    chk(16'({o_sck_oe_n, o_mosi_oe_n, o_tx_ready, o_busy}), 16'h000E);
    i_open = 1'b1;
    repeat (2) tick;
    chk(16'({o_sck_oe_n, o_mosi_oe_n}), 16'h0000);
  endtask
  // one word in a given clock mode
  task automatic t_mode(input logic [1:0] m);
    i_mode = m;
    word = {6'h2A, m, 8'h00};
    repeat (4) tick;
    chk(16'(o_sck), 16'(m[1]));
    sel_n = 1'b0;
    send({m, 6'h19});
    wait_rx;
    chk(16'(o_rx_data), 16'(word[15:8]));
    chk(16'(got[7:0]), 16'({m, 6'h19}));
    sel_n = 1'b1;
  endtask
  // second word queued while first shifts
  task automatic t_b2b;
    i_mode = 2'h1;
    word = 16'h3CC3;
    repeat (4) tick;
    sel_n = 1'b0;
    send(8'h5A);
    send(8'h96);
    chk(16'(o_busy), 16'h0001);
    wait_rx;
    chk(16'(o_rx_data), 16'h003C);
    tick;
    wait_rx;
    chk(16'(o_rx_data), 16'h00C3);
    chk(got, 16'h5A96);
    sel_n = 1'b1;
  endtask
  // main sequence
  initial begin
    repeat (10) tick;
    i_rst = 1'b0;
    t_open;
    for (int m = 0; m < 4; m++) t_mode(2'(m));
    t_b2b;
    print_verdict;
  end
endmodule
`default_nettype wire
